/* File: design/lcm_cell.sv */
// Functional notes
// (RULE1) Normal: four-input table, carry or data three
// (RULE2) Normal: table output joins cascade chain onward
// (RULE3) Independent local and global outputs, table/register
// (RULE4) Packing: fourth input loads register directly
// (RULE5) Packed register keeps enable, clear, preset
// (RULE6) Arithmetic: sum table plus carry table
// (RULE7) Arithmetic allows cascade with carry chain
// (RULE8) Up/down counter: enable, direction, load, carry
// (RULE9) Counter modes: load mux before register
// (RULE10) Counter data loadable via clear/preset paths
// (RULE11) Clearable counter: cascade-in clears, ANDed zero
// (RULE12) Emulated bus: contention low, idle high
// (RULE13) Clear and preset active low, idle high
// (RULE14) Exactly one of six async configurations; acfg codes 6 and 7 select none
// (RULE15) Chip reset overrides all clear/preset/load
// (RULE16) Preset registers may reset to one
// (RULE17) Clear config: either line clears register
// (RULE18) Preset config: line one loads high data
// (RULE19) Clear-preset: line one presets, two clears
// (RULE20) Load-clear: line one loads, two clears
// (RULE21) Load-preset: inverted storage, line two presets
// (RULE22) Load-only: line one loads data three
// (RULE23) Synchronous clock enable, optionally data one
`timescale 1ns/100ps
module lcm_cell
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic first_data_input,
   input wire logic second_data_input,
   input wire logic third_data_input,
   input wire logic fourth_data_input,
   input wire logic carry_in,
   input wire logic cascade_in,
   input wire logic group_control_line_one,
   input wire logic group_control_line_two,
   input wire logic chip_reset_n,
   input wire logic [lcm_pkg::TRI_DRIVERS-1:0] tri_drv_data,
   input wire logic [lcm_pkg::TRI_DRIVERS-1:0] tri_drv_en,
   output logic local_out,
   output logic global_out,
   output logic carry_out,
   output logic cascade_out,
   output logic tri_bus_out
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [lcm_pkg::SYNC_W-1:0] raw_in;
   logic [lcm_pkg::SYNC_W-1:0] meta_q;
   logic [lcm_pkg::SYNC_W-1:0] sync_q;

   assign raw_in = {tri_drv_en, tri_drv_data, chip_reset_n, group_control_line_two, group_control_line_one,
                    cascade_in, carry_in, fourth_data_input, third_data_input, second_data_input, first_data_input};

   genvar gi;
   generate
      for (gi = 0; gi < lcm_pkg::SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               meta_q[gi] <= lcm_pkg::SYNC_RST[gi];
               sync_q[gi] <= lcm_pkg::SYNC_RST[gi];
            end
            else
            begin
               meta_q[gi] <= raw_in[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   logic s_d1, s_d2, s_d3, s_d4, s_cin, s_cas, s_gcl1, s_gcl2, s_chip_n;
   logic [lcm_pkg::TRI_DRIVERS-1:0] s_tri_data;
   logic [lcm_pkg::TRI_DRIVERS-1:0] s_tri_en;

   assign {s_tri_en, s_tri_data, s_chip_n, s_gcl2, s_gcl1, s_cas, s_cin, s_d4, s_d3, s_d2, s_d1} = sync_q;

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   logic [31:0] ctrl_q;
   logic [31:0] lut_q;
   logic [31:0] status;
   logic [31:0] hrdata_q;
   logic [7:0] addr_q;
   logic wr_pend_q;
   logic take;
   logic [31:0] ctrl_view;
   logic [31:0] lut_view;
   logic [31:0] rd_val;

   function automatic logic lcm_hit(input logic [7:0] a, input logic [7:0] ofs);
      lcm_hit = (a[7:2] == ofs[7:2]);
   endfunction

   assign take = hsel && hready && htrans[1] && (hsize == lcm_pkg::HSIZE_WORD);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end
      else
      begin
         wr_pend_q <= take && hwrite;
         if (take)
            addr_q <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctrl_q <= lcm_pkg::CTRL_RST;
      else if (wr_pend_q && lcm_hit(addr_q, lcm_pkg::OFS_CTRL))
         ctrl_q <= hwdata & lcm_pkg::CTRL_WMASK;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         lut_q <= lcm_pkg::LUT_RST;
      else if (wr_pend_q && lcm_hit(addr_q, lcm_pkg::OFS_LUT))
         lut_q <= hwdata & lcm_pkg::LUT_WMASK;
   end

   // Forward a write still in its data phase to a read taken on the same edge
   always_comb
   begin
      ctrl_view = ctrl_q;
      lut_view = lut_q;
      if (wr_pend_q && lcm_hit(addr_q, lcm_pkg::OFS_CTRL))
         ctrl_view = hwdata & lcm_pkg::CTRL_WMASK;
      if (wr_pend_q && lcm_hit(addr_q, lcm_pkg::OFS_LUT))
         lut_view = hwdata & lcm_pkg::LUT_WMASK;
      if (lcm_hit(haddr[7:0], lcm_pkg::OFS_CTRL))
         rd_val = ctrl_view;
      else if (lcm_hit(haddr[7:0], lcm_pkg::OFS_LUT))
         rd_val = lut_view;
      else if (lcm_hit(haddr[7:0], lcm_pkg::OFS_STATUS))
         rd_val = status;
      else
         rd_val = 32'h0000_0000;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_q <= 32'h0000_0000;
      else if (take && !hwrite)
         hrdata_q <= rd_val;
   end

   // ****************************************
   // Configuration decode
   // ****************************************
   lcm_pkg::lcm_mode_e mode;
   lcm_pkg::lcm_acfg_e acfg;
   logic c1, c2, chip_rst, inv, clr_n, pre_n, rst_val, ce;

   assign mode = lcm_pkg::lcm_mode_e'(ctrl_q[lcm_pkg::MODE_LSB +: 2]);
   assign acfg = lcm_pkg::lcm_acfg_e'(ctrl_q[lcm_pkg::ACFG_LSB +: 3]);
   assign c1 = s_gcl1 ^ ctrl_q[lcm_pkg::INV_C1_BIT];
   assign c2 = s_gcl2 ^ ctrl_q[lcm_pkg::INV_C2_BIT];
   assign chip_rst = ctrl_q[lcm_pkg::CHIP_RST_EN_BIT] && !s_chip_n;
   assign ce = ctrl_q[lcm_pkg::CE_D1_BIT] ? s_d1 : 1'b1; // (RULE23)

   // ****************************************
   // Table and datapath
   // ****************************************
   logic [3:0] idx4;
   logic [2:0] idx3;
   logic lut4, sum3, carry3;
   logic lut_res, casc, cy, reg_d, cnt_bit, ld_mux;
   logic store_q;
   logic cell_q;

   assign cell_q = store_q ^ inv; // (RULE21)
   assign idx4 = {s_d4, ctrl_q[lcm_pkg::CARRY_SEL_BIT] ? s_cin : s_d3, s_d2, s_d1}; // (RULE1)

   always_comb
   begin
      case (mode)
         lcm_pkg::MODE_UPDOWN: idx3 = {s_cin, s_cas, cell_q}; // (RULE8)
         lcm_pkg::MODE_CLRCNT: idx3 = {s_cin, s_d2, cell_q};
         default: idx3 = {s_cin, s_d2, s_d1}; // (RULE6)
      endcase
   end

   lcm_lut u_lut
   (
      .mask(lut_q[15:0]),
      .idx4(idx4),
      .idx3(idx3),
      .lut4(lut4),
      .sum3(sum3),
      .carry3(carry3)
   );

   always_comb
   begin
      cnt_bit = s_d2 ? sum3 : cell_q;
      ld_mux = s_d4 ? s_d3 : sum3;
      case (mode)
         lcm_pkg::MODE_NORMAL:
         begin
            lut_res = lut4;
            casc = ctrl_q[lcm_pkg::CASC_EN_BIT] ? (lut4 & s_cas) : lut4; // (RULE2)
            cy = 1'b0;
            reg_d = ctrl_q[lcm_pkg::PACK_BIT] ? s_d4 : casc; // (RULE4)
         end
         lcm_pkg::MODE_ARITH:
         begin
            lut_res = sum3; // (RULE6)
            casc = ctrl_q[lcm_pkg::CASC_EN_BIT] ? (sum3 & s_cas) : sum3; // (RULE7)
            cy = carry3; // (RULE6)
            reg_d = casc;
         end
         lcm_pkg::MODE_UPDOWN:
         begin
            lut_res = sum3;
            casc = sum3;
            cy = carry3; // (RULE8)
            ld_mux = s_d4 ? s_d3 : cnt_bit; // (RULE9)
            reg_d = ld_mux;
         end
         lcm_pkg::MODE_CLRCNT:
         begin
            lut_res = sum3;
            casc = sum3;
            cy = carry3;
            reg_d = ld_mux & s_cas; // (RULE11)
         end
         default:
         begin
            lut_res = 1'b0;
            casc = 1'b0;
            cy = 1'b0;
            reg_d = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Clear and preset control
   // ****************************************
   always_comb
   begin
      inv = 1'b0;
      clr_n = 1'b1; // (RULE13)
      pre_n = 1'b1; // (RULE13)
      rst_val = 1'b0;
      case (acfg) // (RULE14)
         lcm_pkg::ACFG_CLR:
            clr_n = !(c1 || c2); // (RULE17)
         lcm_pkg::ACFG_PRE:
         begin
            pre_n = !(c1 && s_d3); // (RULE18)
            clr_n = !(c1 && !s_d3);
            rst_val = ctrl_q[lcm_pkg::RST_PRESET_BIT]; // (RULE16)
         end
         lcm_pkg::ACFG_CLRPRE:
         begin
            pre_n = !(c1 && s_d3 && !c2); // (RULE19)
            clr_n = !((c1 && !s_d3) || c2); // (RULE19)
            rst_val = ctrl_q[lcm_pkg::RST_PRESET_BIT];
         end
         lcm_pkg::ACFG_LDCLR:
         begin
            pre_n = !(c1 && s_d3 && !c2); // (RULE20)
            clr_n = !((c1 && !s_d3) || c2); // (RULE20)
         end
         lcm_pkg::ACFG_LDPRE:
         begin
            inv = 1'b1; // (RULE21)
            pre_n = !(c1 && s_d3 && !c2);
            clr_n = !((c1 && !s_d3) || c2); // (RULE21)
            rst_val = ctrl_q[lcm_pkg::RST_PRESET_BIT];
         end
         lcm_pkg::ACFG_LDONLY:
         begin
            pre_n = !(c1 && s_d3); // (RULE22)
            clr_n = !(c1 && !s_d3); // (RULE22)
         end
         default:
         begin
            clr_n = 1'b1;
            pre_n = 1'b1;
         end
      endcase
   end

   // ****************************************
   // Cell register
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         store_q <= 1'b0;
      else if (chip_rst)
         store_q <= rst_val ^ inv; // (RULE15)
      else if (!clr_n)
         store_q <= 1'b0; // (RULE10)
      else if (!pre_n)
         store_q <= 1'b1; // (RULE10)
      else if (ce)
         store_q <= reg_d ^ inv; // (RULE5)
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         local_out <= 1'b0;
         global_out <= 1'b0;
         carry_out <= 1'b0;
         cascade_out <= 1'b0;
      end
      else
      begin
         local_out <= ctrl_q[lcm_pkg::LOCAL_SEL_BIT] ? cell_q : lut_res; // (RULE3)
         global_out <= ctrl_q[lcm_pkg::GLOBAL_SEL_BIT] ? cell_q : lut_res; // (RULE3)
         carry_out <= cy;
         cascade_out <= casc;
      end
   end

   lcm_tri_emu u_tri
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .drv_data(s_tri_data),
      .drv_en(s_tri_en),
      .bus_out(tri_bus_out)
   );

   always_comb
   begin
      status = 32'h0000_0000;
      status[lcm_pkg::ST_CELL_BIT] = cell_q;
      status[lcm_pkg::ST_LUT_BIT] = lut_res;
      status[lcm_pkg::ST_LOCAL_BIT] = local_out;
      status[lcm_pkg::ST_GLOBAL_BIT] = global_out;
      status[lcm_pkg::ST_CARRY_BIT] = carry_out;
      status[lcm_pkg::ST_CASC_BIT] = cascade_out;
      status[lcm_pkg::ST_TRI_BIT] = tri_bus_out;
      status[lcm_pkg::ST_CHIP_RST_BIT] = chip_rst;
      status[lcm_pkg::ST_CLR_N_BIT] = clr_n;
      status[lcm_pkg::ST_PRE_N_BIT] = pre_n;
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_chip_reset;
      @(posedge hclk) disable iff (!hresetn)
      chip_rst |=> (store_q == ($past(rst_val) ^ $past(inv)));
   endproperty
   a_chip_reset: assert property (p_chip_reset) else $error("chip reset not applied"); // (RULE15)

   property p_async_clear;
      @(posedge hclk) disable iff (!hresetn)
      (acfg == lcm_pkg::ACFG_CLR && (c1 || c2) && !chip_rst) |=> !store_q;
   endproperty
   a_async_clear: assert property (p_async_clear) else $error("clear config failed"); // (RULE17)

   property p_clrpre_preset;
      @(posedge hclk) disable iff (!hresetn)
      (acfg == lcm_pkg::ACFG_CLRPRE && c1 && !c2 && s_d3 && !chip_rst) |=> store_q;
   endproperty
   a_clrpre_preset: assert property (p_clrpre_preset) else $error("preset by line one failed"); // (RULE19)

   property p_hold_no_ce;
      @(posedge hclk) disable iff (!hresetn)
      (!ce && clr_n && pre_n && !chip_rst) |=> $stable(store_q);
   endproperty
   a_hold_no_ce: assert property (p_hold_no_ce) else $error("register moved without enable"); // (RULE23)

   property p_sync_load;
      @(posedge hclk) disable iff (!hresetn)
      (mode == lcm_pkg::MODE_UPDOWN && s_d4 && ce && clr_n && pre_n && !chip_rst)
         |=> (store_q == ($past(s_d3) ^ $past(inv)));
   endproperty
   a_sync_load: assert property (p_sync_load) else $error("synchronous load missed"); // (RULE9)

   property p_sync_clear;
      @(posedge hclk) disable iff (!hresetn)
      (mode == lcm_pkg::MODE_CLRCNT && !s_cas && ce && clr_n && pre_n && !chip_rst)
         |=> (store_q == $past(inv));
   endproperty
   a_sync_clear: assert property (p_sync_clear) else $error("synchronous clear missed"); // (RULE11)

   property p_local_sel;
      @(posedge hclk) disable iff (!hresetn)
      ctrl_q[lcm_pkg::LOCAL_SEL_BIT] |=> (local_out == $past(cell_q));
   endproperty
   a_local_sel: assert property (p_local_sel) else $error("local output wrong source"); // (RULE3)

   property p_cascade;
      @(posedge hclk) disable iff (!hresetn)
      (mode == lcm_pkg::MODE_NORMAL && ctrl_q[lcm_pkg::CASC_EN_BIT] && !s_cas) |=> !cascade_out;
   endproperty
   a_cascade: assert property (p_cascade) else $error("cascade not gated"); // (RULE2)

   property p_arith_carry;
      @(posedge hclk) disable iff (!hresetn)
      (mode == lcm_pkg::MODE_ARITH) |=> (carry_out == $past(lut_q[{1'b1, idx3}]));
   endproperty
   a_arith_carry: assert property (p_arith_carry) else $error("carry table wrong"); // (RULE6)

endmodule

/* File: design/lcm_pkg.sv */
package lcm_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LUT = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;

   // ****************************************
   // Control register fields
   // ****************************************
   localparam int MODE_LSB = 0;
   localparam int ACFG_LSB = 2;
   localparam int CARRY_SEL_BIT = 5;
   localparam int CASC_EN_BIT = 6;
   localparam int LOCAL_SEL_BIT = 7;
   localparam int GLOBAL_SEL_BIT = 8;
   localparam int PACK_BIT = 9;
   localparam int CE_D1_BIT = 10;
   localparam int CHIP_RST_EN_BIT = 11;
   localparam int RST_PRESET_BIT = 12;
   localparam int INV_C1_BIT = 13;
   localparam int INV_C2_BIT = 14;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_7fff;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] LUT_WMASK = 32'h0000_ffff;
   localparam logic [31:0] LUT_RST = 32'h0000_0000;

   // ****************************************
   // Status register fields
   // ****************************************
   localparam int ST_CELL_BIT = 0;
   localparam int ST_LUT_BIT = 1;
   localparam int ST_LOCAL_BIT = 2;
   localparam int ST_GLOBAL_BIT = 3;
   localparam int ST_CARRY_BIT = 4;
   localparam int ST_CASC_BIT = 5;
   localparam int ST_TRI_BIT = 6;
   localparam int ST_CHIP_RST_BIT = 7;
   localparam int ST_CLR_N_BIT = 8;
   localparam int ST_PRE_N_BIT = 9;

   // ****************************************
   // Bus constants
   // ****************************************
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam int TRI_DRIVERS = 4;
   localparam int SYNC_W = 9 + 2 * TRI_DRIVERS;
   // Chip reset pin idles high through the synchroniser
   localparam logic [SYNC_W-1:0] SYNC_RST = 17'h0_0100;

   // ****************************************
   // Modes
   // ****************************************
   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'b00,
      MODE_ARITH = 2'b01,
      MODE_UPDOWN = 2'b10,
      MODE_CLRCNT = 2'b11
   } lcm_mode_e;

   typedef enum logic [2:0]
   {
      ACFG_CLR = 3'b000,
      ACFG_PRE = 3'b001,
      ACFG_CLRPRE = 3'b010,
      ACFG_LDCLR = 3'b011,
      ACFG_LDPRE = 3'b100,
      ACFG_LDONLY = 3'b101
   } lcm_acfg_e;

endpackage

/* File: design/lcm_lut.sv */
`timescale 1ns/100ps
module lcm_lut
(
   input wire logic [15:0] mask,
   input wire logic [3:0] idx4,
   input wire logic [2:0] idx3,
   output logic lut4,
   output logic sum3,
   output logic carry3
);

   // ****************************************
   // Table lookup
   // ****************************************
   function automatic logic lcm_pick(input logic [15:0] m, input logic [3:0] i);
      lcm_pick = m[i];
   endfunction

   always_comb
   begin
      lut4 = lcm_pick(mask, idx4);
      sum3 = lcm_pick(mask, {1'b0, idx3});
      carry3 = lcm_pick(mask, {1'b1, idx3});
   end

endmodule

/* File: design/lcm_tri_emu.sv */
`timescale 1ns/100ps
module lcm_tri_emu
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [lcm_pkg::TRI_DRIVERS-1:0] drv_data,
   input wire logic [lcm_pkg::TRI_DRIVERS-1:0] drv_en,
   output logic bus_out
);

   // ****************************************
   // Bus resolution
   // ****************************************
   logic one_hot;
   logic sel_bit;

   always_comb
   begin
      one_hot = (drv_en & (drv_en - 1'b1)) == '0;
      sel_bit = |(drv_data & drv_en);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         bus_out <= 1'b1;
      else if (drv_en == '0)
         bus_out <= 1'b1; // (RULE12)
      else if (!one_hot)
         bus_out <= 1'b0; // (RULE12)
      else
         bus_out <= sel_bit;
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_tri_float;
      @(posedge hclk) disable iff (!hresetn)
      (drv_en == '0) |=> bus_out;
   endproperty
   a_tri_float: assert property (p_tri_float) else $error("idle bus not high"); // (RULE12)

   property p_tri_contend;
      @(posedge hclk) disable iff (!hresetn)
      ($countones(drv_en) > 1) |=> !bus_out;
   endproperty
   a_tri_contend: assert property (p_tri_contend) else $error("contended bus not low"); // (RULE12)

endmodule

/* File: dv/lcm_fabric_model.sv */
`timescale 1ns/100ps
// Fabric side: cell pins follow the bench request after each edge
module lcm_fabric_model
(
   input wire logic hclk,
   input wire logic [16:0] want,
   output logic [3:0] d,
   output logic cin,
   output logic casc,
   output logic [1:0] line,
   output logic chip_rst_n,
   output logic [3:0] tdat,
   output logic [3:0] ten
);
   // Lines idle low, chip reset idle high, as the bench requests
   always @(posedge hclk)
   begin
      {ten, tdat, chip_rst_n, line, casc, cin, d} <= want;
   end
endmodule

/* File: dv/tb_logic_cell_modes_and_async_ctrl.sv */
`timescale 1ns/100ps
module tb_logic_cell_modes_and_async_ctrl;
   logic hclk, hresetn, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, line;
   logic [2:0] hsize;
   logic loc, glob, cout, cso, tri_o, cin, casc, crn, d3b, d4b;
   logic [3:0] d, tdat, ten, ix;
   logic [16:0] want, w;
   logic [15:0] mask;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;

   lcm_fabric_model fab (.hclk(hclk), .want(want), .d(d), .cin(cin), .casc(casc), .line(line),
      .chip_rst_n(crn), .tdat(tdat), .ten(ten));
   lcm_cell dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .first_data_input(d[0]), .second_data_input(d[1]),
      .third_data_input(d[2]), .fourth_data_input(d[3]), .carry_in(cin), .cascade_in(casc),
      .group_control_line_one(line[0]), .group_control_line_two(line[1]), .chip_reset_n(crn),
      .tri_drv_data(tdat), .tri_drv_en(ten), .local_out(loc), .global_out(glob),
      .carry_out(cout), .cascade_out(cso), .tri_bus_out(tri_o));

   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   task automatic final_report();
      if (error_cnt == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt++;
         final_report();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   // Single word transfer, entered just after an edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hwdata <= ~wd;
   endtask

   // Pins to outputs take up to five edges with the fabric stage; settled by the sixth
   task automatic drive(input logic [16:0] x);
      want <= x;
      repeat (6) @(posedge hclk);
   endtask

   task automatic crun(input string n, input logic [31:0] c, input logic [16:0] x, input logic e);
      ahb(1'b1, lcm_pkg::OFS_CTRL, c);
      drive(x);
      chk(n, e, glob);
   endtask

   function automatic logic tri_exp(input logic [3:0] dt, input logic [3:0] en);
      if (en == 4'h0)
         return 1'b1;
      if ($countones(en) > 1)
         return 1'b0;
      return |(dt & en);
   endfunction

   // Register value after holding line one (l=0) or line two (l=1)
   function automatic logic aexp(input int c, input int l, input logic x3, input logic x4);
      if (l == 0)
         return (c == 0) ? 1'b0 : (c == 4) ? ~x3 : (c == 1 || c == 2) ? 1'b1 : x3;
      return (c == 1 || c == 5) ? x4 : (c == 4);
   endfunction

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = lcm_pkg::HSIZE_WORD;
      hwdata = 32'h0;
      want = 17'h0_0100;
      void'($urandom(55));
      repeat (5) @(posedge hclk);
      chk("tri idle", 1'b1, tri_o);
      hresetn <= 1'b1;
      ahb(1'b0, lcm_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", lcm_pkg::CTRL_RST, rd);
      ahb(1'b0, 8'h0c, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 1'b0, hresp);
      ahb(1'b1, lcm_pkg::OFS_CTRL, 32'hffff_ffff);
      ahb(1'b0, lcm_pkg::OFS_CTRL, 32'h0);
      chk("ctrl mask", lcm_pkg::CTRL_WMASK, rd);
      for (int i = 0; i < 16; i++)
      begin
         mask = 16'($urandom);
         w = {8'($urandom), 1'b1, 2'b00, 6'($urandom)};
         ix = {w[3], i[0] ? w[4] : w[2], w[1:0]};
         ahb(1'b1, lcm_pkg::OFS_LUT, {16'h0, mask});
         ahb(1'b1, lcm_pkg::OFS_CTRL, i[1] ? 32'h0000_0059 : 32'h0000_0358 | {26'h0, i[0], 5'h0});
         drive(w);
         if (i[1])
         begin
            chk("sum", mask[{1'b0, w[4], w[1:0]}], loc);
            chk("carry", mask[{1'b1, w[4], w[1:0]}], cout);
            chk("arith cascade", mask[{1'b0, w[4], w[1:0]}] & w[5], cso);
         end
         else
         begin
            chk("table", mask[ix], loc);
            chk("cascade", mask[ix] & w[5], cso);
            chk("packed", w[3], glob);
         end
         chk("tri bus", tri_exp(w[12:9], w[16:13]), tri_o);
      end
      for (int c = 0; c < 6; c++)
      begin
         for (int l = 0; l < 2; l++)
         begin
            d3b = (c == 1 || c == 2) ? 1'b1 : 1'($urandom);
            d4b = 1'($urandom);
            w = {8'h0, 1'b1, l[0] ? 2'b10 : 2'b01, 2'b00, d4b, d3b, 2'b00};
            crun("async", 32'h300 | (c << 2), w, aexp(c, l, d3b, d4b));
         end
      end
      drive(17'h0_2300);
      chk("tri one", 1'b1, tri_o);
      drive(17'h0_0100);
      chk("tri idle run", 1'b1, tri_o);
      ahb(1'b0, lcm_pkg::OFS_STATUS, 32'h0);
      chk("clr pre idle", 2'b11, rd[9:8]);
      crun("chip rst", 32'h0b04, 17'h0_0044, 1'b0);
      crun("chip rst pre", 32'h1b04, 17'h0_0000, 1'b1);
      crun("chip rst off", 32'h0304, 17'h0_0008, 1'b1);
      crun("ce load", 32'h0718, 17'h0_0109, 1'b1);
      crun("ce hold", 32'h0718, 17'h0_0100, 1'b1);
      ahb(1'b1, lcm_pkg::OFS_LUT, 32'h0000_8055);
      crun("clr cnt load", 32'h011b, 17'h0_012c, 1'b1);
      crun("clr cnt clear", 32'h011b, 17'h0_010c, 1'b0);
      crun("cnt async load", 32'h010f, 17'h0_0164, 1'b1);
      crun("ud load 0", 32'h011a, 17'h0_0108, 1'b0);
      crun("ud load 1", 32'h011a, 17'h0_010c, 1'b1);
      crun("ud hold", 32'h011a, 17'h0_0130, 1'b1);
      chk("ud carry", 1'b1, cout);
      final_report();
   end
endmodule
